// [src/vsts_map.svh]
`ifndef VSTS_MAP_SVH
`define VSTS_MAP_SVH

// clock and shared tick
`define VSTS_CLK_NS        40
`define VSTS_TICK_NS       1000000
`define VSTS_TW            24

// interval figures, in milliseconds (one tick = 1 ms)
`define VSTS_READY_MS      24'h007530
`define VSTS_SLOT_MS       24'h000064
`define VSTS_DRV_LOC_MS    24'h001388
`define VSTS_DRV_INFO_MS   24'h00EA60
`define VSTS_OFF_GNSS_MS   24'h015F90
`define VSTS_PK_POLL_E_MS  24'h0493E0
`define VSTS_PK_POLL_L_MS  24'h00EA60
`define VSTS_PK_EARLY_MS   24'h6DDD00
`define VSTS_PK_MODEM_MS   24'hDBBA00
`define VSTS_PK_LOC_MS     24'h0493E0
`define VSTS_PK_INFO_MS    24'h0DBBA0
`define VSTS_ALM_LOC_MS    24'h001770
`define VSTS_DUMP_MS       24'h0DBBA0
`define VSTS_SLP_WAKE_MS   24'h0DBBA0
`define VSTS_SLP_GNSS_MS   24'h00EA60

// dump report burst length
`define VSTS_DUMP_BURST    3'h5

`endif

// [src/vsts_pkg.sv]
package vsts_pkg;

  typedef enum logic [9:0] {
    ST_READY   = 10'h001,
    ST_ILLEGAL = 10'h002,
    ST_PWRON   = 10'h004,
    ST_DRIVE   = 10'h008,
    ST_PWROFF  = 10'h010,
    ST_PARK    = 10'h020,
    ST_ALARM   = 10'h040,
    ST_TRANS   = 10'h080,
    ST_WRITE   = 10'h100,
    ST_SLEEP   = 10'h200
  } vsts_state_type;

  typedef enum logic [1:0] {
    DEV_INSTR = 2'h0,
    DEV_MOTOR = 2'h1,
    DEV_BATT  = 2'h2
  } vsts_dev_type;

  typedef struct packed {
    logic ident;
    logic loc;
    logic info;
    logic status;
    logic evt;
    logic host;
  } vsts_upload_type;

  typedef struct packed {
    logic ready_enter;
    logic ready_exit;
  } vsts_lock_cmd_type;

endpackage : vsts_pkg

// [src/vsts_tick.sv]
`timescale 1ns/100ps
`default_nettype none

module vsts_tick #(
  parameter int CYCLES = 25000
) (
  input  wire logic CLK,   // system clock
  input  wire logic NRST,  // async reset, active low
  output logic      tick   // one-cycle pulse every CYCLES clocks
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count == CW'(CYCLES - 1)) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + CW'(1);
      tick  <= 1'b0;
    end
  end

endmodule : vsts_tick

`default_nettype wire

// [src/vsts_timer.sv]
`timescale 1ns/100ps
`default_nettype none

module vsts_timer #(
  parameter int W = 24
) (
  input  wire logic         CLK,      // system clock
  input  wire logic         NRST,     // async reset, active low
  input  wire logic         tick,     // shared 1 ms tick
  input  wire logic         restart,  // clear count, no fire
  input  wire logic [W-1:0] period,   // interval in ticks
  output logic              fire      // one-cycle pulse per interval
);

  logic [W-1:0] count;

  // compare with >= so a shortened period takes effect at once
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      count <= '0;
      fire  <= 1'b0;
    end else if (restart) begin
      count <= '0;
      fire  <= 1'b0;
    end else if (tick && (count >= period - W'(1))) begin
      count <= '0;
      fire  <= 1'b1;
    end else begin
      count <= tick ? count + W'(1) : count;
      fire  <= 1'b0;
    end
  end

endmodule : vsts_timer

`default_nettype wire

// [src/vsts_seq.sv]
`timescale 1ns/100ps
`default_nettype none
`include "vsts_map.svh"

// Overview of operation
// - start button in armed park sends the ready-to-start command to lock_unit
// - ignition opened within the 30 s ready window powers the vehicle on
// - ready window expiring with ignition closed sends lock_unit the exit command
// - ignition opened while armed without a start press raises the alarm
// - at power on, query motor serial number every 100 ms until a reply passes its CRC check
// - only a reply passing its CRC check moves on to normal driving
// - power on enables satellite receiver and uploads the identity set
// - driving keeps receiver on, location every 5 s, vehicle info every 60 s
// - driving polls one device per 100 ms slot, instrument-motor-battery
// - power off saves mileage, clears status, receiver on 90 s then upload
// - parked, poll battery_manager every 5 min for 2 h, then every 1 min
// - parked past 4 h, modem in low power except while a transmission is under way
// - parked, modem on for 4 h, then location 5 min and info 15 min
// - alarming keeps receiver on and uploads location every 6 s
// - dumped while locked uploads 5 times in a row, again every 15 min
// - movement while locked uploads once per detection
// - in write-data the device is the bus slave, the host tool the master
// - after a host write, keep the state, wake network, upload written data
// - battery removed: sleep, bus off, wake 15 min, receiver 60 s, upload
module vsts_seq
  import vsts_pkg::*;
#(
  parameter int TICK_CYCLES = `VSTS_TICK_NS / `VSTS_CLK_NS
) (
  input  wire logic        CLK,           // 25 MHz system clock
  input  wire logic        NRST,          // async reset, active low
  input  wire logic        START_BTN,     // remote start-stop press, pulse
  input  wire logic        IGN_OPEN,      // ignition lock open, level
  input  wire logic        BAT_PRESENT,   // main battery present, level
  input  wire logic        ALARM_REQ,     // alarm cause active, level
  input  wire logic        DUMP_DET,      // vehicle tilted over, level
  input  wire logic        MOVE_DET,      // movement seen, pulse
  input  wire logic        HOST_WR_REQ,   // host tool session, level
  input  wire logic        HOST_WR_DONE,  // host write finished, pulse
  input  wire logic        SN_REPLY,      // serial reply received, pulse
  input  wire logic        SN_CRC_OK,     // reply check passed, with reply
  input  wire logic        TX_DONE,       // modem upload finished, pulse
  output vsts_lock_cmd_type LOCK_CMD,     // lock_unit commands, pulses
  output logic             SN_QUERY,      // motor serial query, pulse
  output logic             POLL_REQ,      // bus poll request, pulse
  output vsts_dev_type     POLL_DEV,      // device polled with POLL_REQ
  output vsts_upload_type  UPLOAD,        // upload requests, pulses
  output logic             GNSS_EN,       // satellite receiver power
  output logic             MODEM_LP,      // modem low-power mode
  output logic             BUS_EN,        // RS-485 module power
  output logic             BUS_SLAVE,     // RS-485 in slave role
  output logic             ALARM,         // alarm active
  output logic             SAVE_MILEAGE,  // store mileage, pulse
  output logic             CLEAR_STATUS,  // clear peer status bits, pulse
  output vsts_state_type   STATE          // current vehicle state
);

  localparam int NT = 4;  // 0 state, 1 poll, 2 location, 3 info

  vsts_state_type       state;
  vsts_state_type       last_state;
  vsts_dev_type         slot;
  vsts_upload_type      next_upl;
  logic                 enter;
  logic                 tick;
  logic [NT-1:0]        fire;
  logic [NT-1:0]        fire_raw;
  logic [`VSTS_TW-1:0]  period [0:NT-1];
  logic [`VSTS_TW-1:0]  park_age;
  logic                 park_early;
  logic                 park_late;
  logic                 tx_busy;
  logic                 slp_gnss;
  logic [2:0]           burst;

  assign STATE      = state;
  assign enter      = (state != last_state);
  // a fire latched under the old state must not act in the new one
  assign fire       = fire_raw & ~{NT{enter}};
  assign park_early = (park_age < `VSTS_PK_EARLY_MS);
  assign park_late  = (park_age >= `VSTS_PK_MODEM_MS);

  vsts_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .CLK  (CLK),
    .NRST (NRST),
    .tick (tick)
  );

  // one prescaler feeds every timer, each cleared on state entry
  for (genvar i = 0; i < NT; i++) begin : g_tmr
    vsts_timer #(
      .W (`VSTS_TW)
    ) u_tmr (
      .CLK     (CLK),
      .NRST    (NRST),
      .tick    (tick),
      .restart (enter),
      .period  (period[i]),
      .fire    (fire_raw[i])
    );
  end

  always_comb begin
    if (state == ST_PWROFF) begin
      period[0] = `VSTS_OFF_GNSS_MS;
    end else if (state == ST_TRANS) begin
      period[0] = `VSTS_DUMP_MS;
    end else if (state == ST_SLEEP) begin
      period[0] = slp_gnss ? `VSTS_SLP_GNSS_MS : `VSTS_SLP_WAKE_MS;
    end else begin
      period[0] = `VSTS_READY_MS;
    end
    if (state == ST_PARK) begin
      period[1] = park_early ? `VSTS_PK_POLL_E_MS
                             : `VSTS_PK_POLL_L_MS;
    end else begin
      period[1] = `VSTS_SLOT_MS;
    end
    if (state == ST_DRIVE) begin
      period[2] = `VSTS_DRV_LOC_MS;
      period[3] = `VSTS_DRV_INFO_MS;
    end else if (state == ST_ALARM) begin
      period[2] = `VSTS_ALM_LOC_MS;
      period[3] = `VSTS_PK_INFO_MS;
    end else begin
      period[2] = `VSTS_PK_LOC_MS;
      period[3] = `VSTS_PK_INFO_MS;
    end
  end

  // battery loss overrides every state
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state <= ST_PARK;
    end else if (!BAT_PRESENT && state != ST_SLEEP) begin
      state <= ST_SLEEP;
    end else begin
      unique case (state)
        ST_PARK: begin
          if (START_BTN) begin
            state <= ST_READY;
          end else if (IGN_OPEN) begin
            state <= ST_ILLEGAL;
          end else if (ALARM_REQ) begin
            state <= ST_ALARM;
          end else if (HOST_WR_REQ) begin
            state <= ST_WRITE;
          end else if (DUMP_DET || MOVE_DET) begin
            state <= ST_TRANS;
          end
        end
        ST_READY: begin
          if (IGN_OPEN) begin
            state <= ST_PWRON;
          end else if (fire[0]) begin
            state <= ST_PARK;
          end
        end
        ST_ILLEGAL: begin
          state <= ST_ALARM;
        end
        ST_ALARM: begin
          if (!ALARM_REQ && !IGN_OPEN) begin
            state <= ST_PARK;
          end
        end
        ST_PWRON: begin
          if (!IGN_OPEN) begin
            state <= ST_PWROFF;
          end else if (SN_REPLY && SN_CRC_OK) begin
            state <= ST_DRIVE;
          end
        end
        ST_DRIVE: begin
          if (!IGN_OPEN) begin
            state <= ST_PWROFF;
          end
        end
        ST_PWROFF: begin
          if (fire[0]) begin
            state <= ST_PARK;
          end
        end
        ST_TRANS: begin
          if (burst == 3'h0 && !tx_busy && !DUMP_DET) begin
            state <= ST_PARK;
          end
        end
        ST_WRITE: begin
          // state is held through the write, left only when host goes and no upload is still busy
          if (!HOST_WR_REQ && !tx_busy) begin
            state <= ST_PARK;
          end
        end
        ST_SLEEP: begin
          if (BAT_PRESENT) begin
            state <= ST_PARK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      last_state <= ST_PARK;
    end else begin
      last_state <= state;
    end
  end

  // parked age runs across the parked sub-states, cleared outside them
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      park_age <= '0;
    end else if (state inside {ST_READY, ST_PWRON, ST_DRIVE,
                               ST_PWROFF, ST_SLEEP}) begin
      park_age <= '0;
    end else if (tick && !park_late) begin
      park_age <= park_age + `VSTS_TW'(1);
    end
  end

  always_comb begin
    next_upl       = '0;
    next_upl.ident = enter && state == ST_PWRON;
    next_upl.loc   = fire[2] && (state == ST_DRIVE
                     || state == ST_ALARM
                     || (state == ST_PARK && park_late))
                     || (state == ST_SLEEP && fire[0] && slp_gnss);
    next_upl.info  = fire[3] && (state == ST_DRIVE
                     || (state == ST_PARK && park_late));
    next_upl.status = state == ST_PWROFF && fire[0];
    next_upl.evt   = state == ST_TRANS && burst != 3'h0 && !tx_busy;
    next_upl.host  = state == ST_WRITE && HOST_WR_DONE;
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      UPLOAD <= '0;
    end else begin
      UPLOAD <= next_upl;
    end
  end

  // set wins over TX_DONE so a back-to-back upload keeps the modem awake
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tx_busy <= 1'b0;
    end else if (|next_upl) begin
      tx_busy <= 1'b1;
    end else if (TX_DONE) begin
      tx_busy <= 1'b0;
    end
  end

  // burst is preloaded while parked so it is valid on the first trans cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      burst <= 3'h0;
    end else if (state == ST_PARK) begin
      burst <= DUMP_DET ? `VSTS_DUMP_BURST
                        : {2'h0, MOVE_DET};
    end else if (state == ST_TRANS && fire[0] && DUMP_DET) begin
      burst <= `VSTS_DUMP_BURST;
    end else if (next_upl.evt) begin
      burst <= burst - 3'h1;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      slp_gnss <= 1'b0;
    end else if (enter) begin
      slp_gnss <= 1'b0;
    end else if (state == ST_SLEEP && fire[0]) begin
      slp_gnss <= !slp_gnss;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      slot <= DEV_INSTR;
    end else if (enter) begin
      slot <= DEV_INSTR;
    end else if (state == ST_DRIVE && fire[1]) begin
      unique case (slot)
        DEV_INSTR: slot <= DEV_MOTOR;
        DEV_MOTOR: slot <= DEV_BATT;
        DEV_BATT:  slot <= DEV_INSTR;
        default:   slot <= DEV_INSTR;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      POLL_REQ <= 1'b0;
      POLL_DEV <= DEV_INSTR;
      SN_QUERY <= 1'b0;
    end else begin
      POLL_REQ <= fire[1] && (state == ST_DRIVE
                  || state == ST_PARK);
      POLL_DEV <= (state == ST_DRIVE) ? slot : DEV_BATT;
      SN_QUERY <= state == ST_PWRON && (enter || fire[1]);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      LOCK_CMD <= '0;
    end else begin
      LOCK_CMD.ready_enter <= enter && state == ST_READY;
      LOCK_CMD.ready_exit  <= state == ST_READY && fire[0]
                              && !IGN_OPEN;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SAVE_MILEAGE <= 1'b0;
      CLEAR_STATUS <= 1'b0;
    end else begin
      SAVE_MILEAGE <= enter && state == ST_PWROFF;
      CLEAR_STATUS <= enter && state == ST_PWROFF;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      GNSS_EN <= 1'b0;
    end else begin
      GNSS_EN <= (state inside {ST_PWRON, ST_DRIVE, ST_PWROFF,
                                ST_ALARM, ST_TRANS, ST_WRITE})
                 || (state == ST_SLEEP && slp_gnss);
    end
  end

  // modem wakes in the same cycle an upload request appears
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MODEM_LP <= 1'b0;
    end else begin
      MODEM_LP <= ((state == ST_PARK && park_late)
                   || state == ST_SLEEP)
                  && !(|next_upl)
                  && !(tx_busy && !TX_DONE);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      BUS_EN    <= 1'b1;
      BUS_SLAVE <= 1'b0;
      ALARM     <= 1'b0;
    end else begin
      BUS_EN    <= state != ST_SLEEP;
      BUS_SLAVE <= state == ST_WRITE;
      ALARM     <= state inside {ST_ILLEGAL, ST_ALARM};
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  AST_LOCK_ENTER: assert property (
    (state == ST_PARK && BAT_PRESENT && START_BTN)
      |=> ##1 LOCK_CMD.ready_enter)
    else $error("ready-to-start command missing");

  AST_READY_ON: assert property (
    (state == ST_READY && BAT_PRESENT && IGN_OPEN) |=> state == ST_PWRON)
    else $error("ignition open did not power on");

  AST_READY_EXIT: assert property (
    (state == ST_READY && BAT_PRESENT && !IGN_OPEN && fire[0])
      |=> state == ST_PARK && LOCK_CMD.ready_exit)
    else $error("ready window expiry not handled");

  AST_ILLEGAL: assert property (
    (state == ST_PARK && BAT_PRESENT && !START_BTN && IGN_OPEN)
      |=> ##1 ALARM)
    else $error("illegal ignition open did not alarm");

  AST_SN_QUERY: assert property (
    (state == ST_PWRON && fire[1]) |=> SN_QUERY)
    else $error("serial query not repeated");

  AST_CRC_GATE: assert property (
    (state == ST_PWRON && BAT_PRESENT && IGN_OPEN && SN_REPLY && !SN_CRC_OK)
      |=> state == ST_PWRON)
    else $error("failed check left power on");

  AST_DRV_POLL: assert property (
    (state == ST_DRIVE && fire[1]) |=> POLL_REQ && POLL_DEV == $past(slot))
    else $error("driving poll slot wrong");

  AST_PWROFF: assert property (
    (state != ST_PWROFF ##1 state == ST_PWROFF)
      |=> SAVE_MILEAGE && CLEAR_STATUS && GNSS_EN)
    else $error("power off entry actions missing");

  AST_MODEM_WAKE: assert property (
    (|UPLOAD) |-> !MODEM_LP)
    else $error("modem asleep during upload");

  AST_WRITE_SLAVE: assert property (
    (state == ST_WRITE && $past(state) == ST_WRITE) |-> BUS_SLAVE)
    else $error("write state not bus slave");

  AST_HOST_UPL: assert property (
    (state == ST_WRITE && BAT_PRESENT && HOST_WR_REQ && HOST_WR_DONE)
      |=> UPLOAD.host && state == ST_WRITE)
    else $error("host data not uploaded");

  AST_SLEEP_BUS: assert property (
    (state == ST_SLEEP && $past(state) == ST_SLEEP) |-> !BUS_EN)
    else $error("bus powered in sleep");

  COV_START: cover property (state == ST_READY ##1 state == ST_PWRON);
  COV_DRIVE: cover property (state == ST_DRIVE ##1 state == ST_PWROFF);
  COV_DUMP:  cover property (state == ST_TRANS && UPLOAD.evt);
  COV_WAKE:  cover property (state == ST_SLEEP && UPLOAD.loc);

endmodule : vsts_seq

`default_nettype wire

// [tb/vsts_peer.sv]
`timescale 1ns/100ps
`default_nettype none

module vsts_peer
  import vsts_pkg::*;
(
  input  wire logic            CLK,       // system clock
  input  wire logic            NRST,      // async reset, active low
  input  wire logic            SN_QUERY,  // serial query from the block
  input  wire vsts_upload_type UPLOAD,    // upload requests
  input  wire logic            crc_good,  // reply passes its check
  input  wire logic [7:0]      lag,       // answer delay in clocks
  output logic                 SN_REPLY,  // serial reply, pulse
  output logic                 SN_CRC_OK, // check result with reply
  output logic                 TX_DONE    // modem upload finished
);
  int sn_wait;
  int tx_wait;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sn_wait <= 0;
      tx_wait <= 0;
      SN_REPLY <= 1'b0;
      SN_CRC_OK <= 1'b0;
      TX_DONE <= 1'b0;
    end else begin
      SN_REPLY <= 1'b0;
      TX_DONE <= 1'b0;
      // flag means nothing outside a reply, so it never holds still
      SN_CRC_OK <= ~SN_CRC_OK;
      if (SN_QUERY) begin
        sn_wait <= lag + 1;
      end else if (sn_wait == 1) begin
        SN_REPLY <= 1'b1;
        SN_CRC_OK <= crc_good;
      end
      if (!SN_QUERY && sn_wait > 0) begin
        sn_wait <= sn_wait - 1;
      end
      if (UPLOAD != '0) begin
        tx_wait <= lag + 1;
      end else if (tx_wait == 1) begin
        TX_DONE <= 1'b1;
      end
      if (UPLOAD == '0 && tx_wait > 0) begin
        tx_wait <= tx_wait - 1;
      end
    end
  end
endmodule : vsts_peer

`default_nettype wire

// [tb/test_vehicle_state_task_sequencer.sv]
`timescale 1ns/100ps
`default_nettype none

module test_vehicle_state_task_sequencer
  import vsts_pkg::*;
;
  localparam int TC = 2;
  logic CLK, NRST, START_BTN, IGN_OPEN, BAT_PRESENT, ALARM_REQ, DUMP_DET;
  logic MOVE_DET, HOST_WR_REQ, HOST_WR_DONE, SN_REPLY, SN_CRC_OK, TX_DONE;
  logic SN_QUERY, POLL_REQ, GNSS_EN, MODEM_LP, BUS_EN, BUS_SLAVE, ALARM;
  logic SAVE_MILEAGE, CLEAR_STATUS, crc_good;
  logic [7:0] lag;
  vsts_lock_cmd_type LOCK_CMD;
  vsts_dev_type POLL_DEV, pexp;
  vsts_upload_type UPLOAD;
  vsts_state_type STATE, prev;
  int mismatches, check_count, cyc, evt_n, t0;
  int last[3];
  int n[3];

  vsts_seq #(.TICK_CYCLES(TC)) dut (.CLK(CLK), .NRST(NRST),
    .START_BTN(START_BTN), .IGN_OPEN(IGN_OPEN), .BAT_PRESENT(BAT_PRESENT),
    .ALARM_REQ(ALARM_REQ), .DUMP_DET(DUMP_DET), .MOVE_DET(MOVE_DET),
    .HOST_WR_REQ(HOST_WR_REQ), .HOST_WR_DONE(HOST_WR_DONE),
    .SN_REPLY(SN_REPLY), .SN_CRC_OK(SN_CRC_OK), .TX_DONE(TX_DONE),
    .LOCK_CMD(LOCK_CMD), .SN_QUERY(SN_QUERY), .POLL_REQ(POLL_REQ),
    .POLL_DEV(POLL_DEV), .UPLOAD(UPLOAD), .GNSS_EN(GNSS_EN),
    .MODEM_LP(MODEM_LP), .BUS_EN(BUS_EN), .BUS_SLAVE(BUS_SLAVE),
    .ALARM(ALARM), .SAVE_MILEAGE(SAVE_MILEAGE),
    .CLEAR_STATUS(CLEAR_STATUS), .STATE(STATE));

  vsts_peer peer (.CLK(CLK), .NRST(NRST), .SN_QUERY(SN_QUERY),
    .UPLOAD(UPLOAD), .crc_good(crc_good), .lag(lag), .SN_REPLY(SN_REPLY),
    .SN_CRC_OK(SN_CRC_OK), .TX_DONE(TX_DONE));

  function automatic int ms(input int t);
    return t * TC;
  endfunction : ms

  function automatic vsts_dev_type next_dev(input vsts_dev_type d);
    return (d == DEV_BATT) ? DEV_INSTR : vsts_dev_type'(d + 2'h1);
  endfunction : next_dev

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic gap(input int k, input int per);
    // the first query follows entry, not the timer, so its gap is skipped
    if (n[k] >= ((k == 0) ? 2 : 1)) chk(cyc - last[k], per);
    last[k] = cyc;
    n[k]++;
  endtask : gap

  task automatic step(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask : step

  task automatic wait_state(input vsts_state_type s, input int lim);
    for (int i = 0; i < lim && STATE !== s; i++) step(1);
    chk(STATE, s);
  endtask : wait_state

  task automatic pulse(ref logic sig);
    @(negedge CLK);
    sig = 1'b1;
    @(negedge CLK);
    sig = 1'b0;
    #1;
  endtask : pulse

  task automatic do_reset;
    @(negedge CLK);
    NRST = 1'b0;
    repeat (20) @(negedge CLK);
    NRST = 1'b1;
  endtask : do_reset

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  // interval watcher, restarted on every state change
  always @(posedge CLK) begin
    #1;
    cyc++;
    if (STATE !== prev) begin
      n = '{0, 0, 0};
      pexp = DEV_INSTR;
    end
    prev = STATE;
    if (SN_QUERY) gap(0, ms(100));
    if (POLL_REQ && STATE === ST_DRIVE) begin
      chk(POLL_DEV, pexp);
      pexp = next_dev(pexp);
      gap(1, ms(100));
    end
    if (UPLOAD.loc && STATE === ST_DRIVE) gap(2, ms(5000));
    if (UPLOAD.evt) evt_n++;
  end

  initial begin
    repeat (95000) @(posedge CLK);
    mismatches++;
    wrap_up();
  end

  initial begin
    {START_BTN, IGN_OPEN, ALARM_REQ, DUMP_DET, MOVE_DET} = '0;
    {HOST_WR_REQ, HOST_WR_DONE, crc_good} = '0;
    BAT_PRESENT = 1'b1;
    NRST = 1'b0;
    void'($urandom(79));
    lag = 8'($urandom_range(1, 40));
    do_reset();
    step(1);
    chk({STATE, BUS_EN, GNSS_EN}, {ST_PARK, 2'b10});
    pulse(START_BTN);
    chk(STATE, ST_READY);
    step(1);
    chk(LOCK_CMD, 2'b10);
    repeat ($urandom_range(1, 500)) @(negedge CLK);
    IGN_OPEN = 1'b1;
    step(1);
    chk(STATE, ST_PWRON);
    step(1);
    chk({UPLOAD.ident, SN_QUERY}, 2'b11);
    step(1);
    chk(GNSS_EN, 1'b1);
    // bad replies must keep the block querying in power on
    t0 = $urandom_range(3, 4);
    for (int i = 0; i < 200 && n[0] < t0; i++) step(ms(5));
    chk(STATE, ST_PWRON);
    crc_good = 1'b1;
    wait_state(ST_DRIVE, ms(110));
    step(ms(10100));
    chk(n[1] > 3, 1'b1);
    chk(n[2], 2);
    chk(GNSS_EN, 1'b1);
    @(negedge CLK);
    IGN_OPEN = 1'b0;
    step(1);
    chk(STATE, ST_PWROFF);
    step(1);
    chk({SAVE_MILEAGE, CLEAR_STATUS}, 2'b11);
    step(1);
    chk(GNSS_EN, 1'b1);
    do_reset();
    @(negedge CLK);
    IGN_OPEN = 1'b1;
    step(1);
    chk(STATE, ST_ILLEGAL);
    step(2);
    chk(ALARM, 1'b1);
    @(negedge CLK);
    IGN_OPEN = 1'b0;
    wait_state(ST_PARK, 20);
    evt_n = 0;
    pulse(MOVE_DET);
    wait_state(ST_PARK, 400);
    chk(evt_n, 1);
    @(negedge CLK);
    HOST_WR_REQ = 1'b1;
    step(2);
    chk({STATE, BUS_SLAVE}, {ST_WRITE, 1'b1});
    pulse(HOST_WR_DONE);
    chk({UPLOAD.host, STATE}, {1'b1, ST_WRITE});
    HOST_WR_REQ = 1'b0;
    wait_state(ST_PARK, 400);
    chk(MODEM_LP, 1'b0);
    @(negedge CLK);
    BAT_PRESENT = 1'b0;
    step(2);
    chk({STATE, BUS_EN, MODEM_LP}, {ST_SLEEP, 2'b01});
    @(negedge CLK);
    BAT_PRESENT = 1'b1;
    wait_state(ST_PARK, 20);
    pulse(START_BTN);
    t0 = cyc;
    for (int i = 0; i < ms(30100) && !LOCK_CMD.ready_exit; i++) step(1);
    chk(cyc - t0 >= ms(29999) && cyc - t0 <= ms(30001) + 4, 1'b1);
    step(1);
    chk(STATE, ST_PARK);
    wrap_up();
  end
endmodule : test_vehicle_state_task_sequencer

`default_nettype wire
